/* logic/tsr_pkg.sv */
// Shared constants and types of the temperature serial readout
package tsr_pkg;

	// -------------------------------------------------------------
	// Clock and timing
	// -------------------------------------------------------------
	localparam int CLK_HZ       = 50_000_000;
	localparam int PERIOD_MS    = 1500;          // Auto conversion period
	localparam int CONV_US      = 1200;          // Conversion time
	localparam int PERIOD_CYC   = PERIOD_MS * (CLK_HZ / 1000);
	localparam int CONV_CYC     = CONV_US * (CLK_HZ / 1_000_000);
	localparam int TIMER_W      = 27;

	// -------------------------------------------------------------
	// Frame and register layout
	// -------------------------------------------------------------
	localparam int TEMP_W       = 14;
	localparam int WORD_W       = 16;
	localparam int CNT_W        = 4;
	localparam int PD_BIT       = 13;            // Third bit of the stream
	localparam int LEAD_ZEROS   = 2;
	localparam logic [CNT_W-1:0]  LAST_RISE = 4'hF;
	localparam logic [TEMP_W-1:0] TEMP_RST  = 14'h0000;
	localparam logic [WORD_W-1:0] CTRL_RST  = 16'h0000;
	localparam int FIFO_DEPTH   = 16;

	// -------------------------------------------------------------
	// Sequencer states
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_CONV = 3'b010,
		ST_SHUT = 3'b100
	} tsr_state_type;

	// Rising edge of a sampled level
	function automatic logic tsr_rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	// Output bit of a frame: leading zeros then value, MSB first
	function automatic logic tsr_frame_bit(input logic [TEMP_W-1:0] v,
		input logic [CNT_W-1:0] idx);
		logic [WORD_W-1:0] w;
		w = {2'h0, v};
		return w[4'hF - idx];
	endfunction

endpackage

/* logic/tsr_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tsr_sync #(
	parameter int               W   = 1,
	parameter logic [W-1:0]     RST = '0
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// Levels
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tsr_sync_type;

	tsr_sync_type r_q;
	tsr_sync_type r_d;

	// Shift through two stages
	always_comb begin
		r_d    = r_q;
		r_d.s1 = i_async;
		r_d.s2 = r_q.s1;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			r_q <= {RST, RST};
		end else begin
			r_q <= r_d;
		end
	end

	assign o_sync = r_q.s2;

endmodule

/* logic/tsr_fifo.sv */
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps
module tsr_fifo #(
	parameter int W     = 14,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// Fill side
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	// Drain side
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic      [W-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             used;
	} tsr_fifo_type;

	tsr_fifo_type r_q;
	tsr_fifo_type r_d;
	logic         push;
	logic         pop;

	// Handshakes on both sides
	assign o_in_ready  = (r_q.used != (AW+1)'(DEPTH));
	assign o_out_valid = (r_q.used != '0);
	assign o_out_data  = r_q.mem[r_q.rd];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Pointer and storage update
	always_comb begin
		r_d = r_q;
		if (push) begin
			r_d.mem[r_q.wr] = i_in_data;
			r_d.wr          = r_q.wr + 1'b1;
		end
		if (pop) begin
			r_d.rd = r_q.rd + 1'b1;
		end
		r_d.used = r_q.used + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

endmodule

/* logic/tsr_top.sv */
// Temperature sensor serial readout: sequencer, serial port, registers
`timescale 1ns/1ps
module tsr_top #(
	parameter int PERIOD_CYCLES = tsr_pkg::PERIOD_CYC,
	parameter int CONV_CYCLES   = tsr_pkg::CONV_CYC
) (
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_reset,
	// Serial port pins
	input  wire logic                      i_cs_n,
	input  wire logic                      i_sclk,
	input  wire logic                      i_din,
	output logic                           o_dout,
	output logic                           o_dout_oe,
	// Analog core
	input  wire logic [tsr_pkg::TEMP_W-1:0] i_adc_code,
	output logic                           o_analog_on,
	// Status
	output logic                           o_shutdown
);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	typedef struct packed {
		tsr_pkg::tsr_state_type             st;
		logic [tsr_pkg::TIMER_W-1:0]        timer;
		logic [tsr_pkg::TIMER_W-1:0]        conv;
		logic                               sclk_prev;
		logic                               cs_prev;
		logic [tsr_pkg::CNT_W-1:0]          cnt;
		logic                               first;
		logic [tsr_pkg::WORD_W-1:0]         sh;
		logic [tsr_pkg::WORD_W-1:0]         ctrl;
		logic                               pd;
		logic [tsr_pkg::TEMP_W-1:0]         held;
		logic [tsr_pkg::TEMP_W-1:0]         temp;
		logic                               dout;
		logic                               oe;
		logic                               analog_on;
	} tsr_regs_type;

	tsr_regs_type r_q;
	tsr_regs_type r_d;

	logic                          cs_s;
	logic                          sclk_s;
	logic                          din_s;
	logic                          sel;
	logic                          rise;
	logic                          fall;
	logic                          access_end;
	logic                          timer_end;
	logic                          conv_end;
	logic                          load_ctrl;
	logic [tsr_pkg::WORD_W-1:0]    sh_next;
	logic                          fifo_in_ready;
	logic                          fifo_out_valid;
	logic [tsr_pkg::TEMP_W-1:0]    fifo_out_data;

	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	tsr_sync #(
		.W   (3),
		.RST (3'h7)
	) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_cs_n, i_sclk, i_din}),
		.o_sync  ({cs_s, sclk_s, din_s})
	);

	// -------------------------------------------------------------
	// Result FIFO between converter and buffer register
	// -------------------------------------------------------------
	tsr_fifo #(
		.W     (tsr_pkg::TEMP_W),
		.DEPTH (tsr_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_in_valid  (conv_end),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (i_adc_code),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (cs_s),
		.o_out_data  (fifo_out_data)
	);

	// -------------------------------------------------------------
	// Decoded events
	// -------------------------------------------------------------
	assign sel        = ~cs_s;
	assign rise       = sel & tsr_pkg::tsr_rise(sclk_s, r_q.sclk_prev);
	assign fall       = sel & tsr_pkg::tsr_rise(~sclk_s, ~r_q.sclk_prev);
	assign access_end = tsr_pkg::tsr_rise(cs_s, r_q.cs_prev);
	assign timer_end  = (r_q.timer ==
		tsr_pkg::TIMER_W'(PERIOD_CYCLES - 1));
	assign conv_end   = (r_q.st == tsr_pkg::ST_CONV) &&
		(r_q.conv == tsr_pkg::TIMER_W'(CONV_CYCLES - 1));
	assign load_ctrl  = rise && (r_q.cnt == tsr_pkg::LAST_RISE);
	assign sh_next    = {r_q.sh[tsr_pkg::WORD_W-2:0], din_s};

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb begin
		r_d           = r_q;
		r_d.sclk_prev = sclk_s;
		r_d.cs_prev   = cs_s;
		r_d.oe        = sel;

		// Bit counter only moves while selected
		if (!sel) begin
			r_d.cnt   = '0;
			r_d.first = 1'b0;
		end else if (rise) begin
			r_d.sh  = sh_next;
			r_d.cnt = r_q.cnt + 1'b1;
		end

		// Control word takes effect at the 16th rise
		if (load_ctrl) begin
			r_d.ctrl = sh_next;
			r_d.pd   = sh_next[tsr_pkg::PD_BIT];
		end

		// Falling edge: register load and output bit
		if (fall) begin
			if (!r_q.first) begin
				r_d.first = 1'b1;
				r_d.temp  = r_q.held;
				r_d.dout  = tsr_pkg::tsr_frame_bit(r_q.held, r_q.cnt);
			end else begin
				r_d.dout  = tsr_pkg::tsr_frame_bit(r_q.temp, r_q.cnt);
			end
		end

		// Buffer register drains the FIFO between accesses
		if (fifo_out_valid && cs_s) begin
			r_d.held = fifo_out_data;
		end

		// Conversion sequencer
		r_d.timer = r_q.timer + 1'b1;
		case (r_q.st)
			tsr_pkg::ST_RUN: begin
				r_d.conv = '0;
				if (load_ctrl && sh_next[tsr_pkg::PD_BIT]) begin
					r_d.st = tsr_pkg::ST_SHUT;
				end else if (timer_end || access_end) begin
					r_d.st    = tsr_pkg::ST_CONV;
					r_d.timer = '0;
				end
			end
			tsr_pkg::ST_CONV: begin
				if (access_end) begin
					r_d.timer = '0;
				end
				if (!conv_end) begin
					r_d.conv = r_q.conv + 1'b1;
				end else if (fifo_in_ready) begin
					r_d.conv  = '0;
					r_d.st    = r_d.pd ? tsr_pkg::ST_SHUT
						: tsr_pkg::ST_RUN;
				end
			end
			tsr_pkg::ST_SHUT: begin
				r_d.timer = '0;
				r_d.conv  = '0;
				if (load_ctrl && !sh_next[tsr_pkg::PD_BIT]) begin
					r_d.st = tsr_pkg::ST_CONV;
				end
			end
			default: begin
				r_d.st = tsr_pkg::ST_RUN;
			end
		endcase
		r_d.analog_on = (r_d.st == tsr_pkg::ST_CONV);
	end

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			r_q           <= '0;
			r_q.st        <= tsr_pkg::ST_RUN;
			r_q.sclk_prev <= 1'b1;
			r_q.cs_prev   <= 1'b1;
			r_q.ctrl      <= tsr_pkg::CTRL_RST;
			r_q.temp      <= tsr_pkg::TEMP_RST;
			r_q.held      <= tsr_pkg::TEMP_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from flops; result codes pass unscaled
	assign o_dout      = r_q.dout;
	assign o_dout_oe   = r_q.oe;
	assign o_analog_on = r_q.analog_on;
	assign o_shutdown  = r_q.pd;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	chk_sample_rise: assert property (
		rise |=> r_q.sh[0] == $past(din_s))
		else $error("input bit not sampled on rise");

	chk_idle_ignore: assert property (
		cs_s && r_q.cs_prev |=> $stable(r_q.sh) && r_q.cnt == '0)
		else $error("clock acted while deselected");

	chk_lead_zeros: assert property (
		fall && r_q.cnt < 4'h2 |=> !o_dout)
		else $error("leading bit not zero");

	chk_first_load: assert property (
		fall && !r_q.first |=> r_q.temp == $past(r_q.held))
		else $error("register not loaded at first fall");

	chk_temp_hold: assert property (
		!(fall && !r_q.first) |=> $stable(r_q.temp))
		else $error("register changed outside first fall");

	chk_pd_load: assert property (
		load_ctrl |=> r_q.pd == $past(r_q.sh[12]))
		else $error("shutdown bit not loaded at 16th rise");

	chk_partial_drop: assert property (
		access_end && !load_ctrl |=> $stable(r_q.pd))
		else $error("partial control word took effect");

	chk_release_out: assert property (
		access_end |=> !o_dout_oe ##1 !o_dout_oe)
		else $error("output not released after deselect");

	chk_access_conv: assert property (
		r_q.st == tsr_pkg::ST_RUN && access_end && !load_ctrl
		|=> r_q.st == tsr_pkg::ST_CONV ##1 o_analog_on)
		else $error("access end did not start conversion");

	chk_shut_quiet: assert property (
		r_q.st == tsr_pkg::ST_SHUT && !load_ctrl |=> !o_analog_on)
		else $error("analog on during shutdown");

	chk_fall_update: assert property (
		!fall |=> $stable(o_dout))
		else $error("output bit moved without a falling edge");

	chk_timer_conv: assert property (
		r_q.st == tsr_pkg::ST_RUN && timer_end && !load_ctrl
		|=> r_q.st == tsr_pkg::ST_CONV)
		else $error("period expiry did not start conversion");

	chk_conv_done: assert property (
		conv_end && fifo_in_ready |=> !o_analog_on)
		else $error("analog stayed on after conversion end");

	chk_shut_timer: assert property (
		r_q.st == tsr_pkg::ST_SHUT |=> r_q.timer == '0)
		else $error("period timer ran during shutdown");

	chk_access_timer: assert property (
		access_end && r_q.st != tsr_pkg::ST_SHUT |=> r_q.timer == '0)
		else $error("access end did not restart timer");

	chk_wake_conv: assert property (
		r_q.st == tsr_pkg::ST_SHUT && load_ctrl &&
		!sh_next[tsr_pkg::PD_BIT] |=> o_analog_on)
		else $error("wake did not start a conversion");

	chk_buf_defer: assert property (
		!cs_s |=> $stable(r_q.held))
		else $error("buffer changed while selected");

	chk_conv_keep: assert property (
		r_q.st == tsr_pkg::ST_CONV && !conv_end
		|=> r_q.st == tsr_pkg::ST_CONV)
		else $error("conversion aborted early");

	chk_count_wrap: assert property (
		rise && r_q.cnt == tsr_pkg::LAST_RISE |=> r_q.cnt == '0)
		else $error("bit counter did not wrap after 16 rises");

	chk_shut_enter: assert property (
		load_ctrl && sh_next[tsr_pkg::PD_BIT] |=> o_shutdown)
		else $error("shutdown request not taken");

	chk_count_clear: assert property (
		!sel |=> r_q.cnt == '0 && !r_q.first)
		else $error("bit counter not cleared while deselected");

	chk_sign_out: assert property (
		fall && r_q.first && r_q.cnt == 4'h2
		|=> o_dout == $past(r_q.temp[13]))
		else $error("sign bit not first after leading zeros");

	chk_conv_hold: assert property (
		$rose(r_q.st == tsr_pkg::ST_CONV)
		|-> (r_q.st == tsr_pkg::ST_CONV) [*8])
		else $error("conversion ended too early");

	cov_shutdown: cover property (
		r_q.st == tsr_pkg::ST_RUN ##1 r_q.st == tsr_pkg::ST_SHUT);
	cov_wake: cover property (
		r_q.st == tsr_pkg::ST_SHUT ##1 r_q.st == tsr_pkg::ST_CONV);
	cov_repeat: cover property (
		load_ctrl && r_q.first ##[1:200] fall && r_q.cnt == '0);
	cov_fifo_full: cover property (conv_end && !fifo_in_ready);

endmodule

/* bench/tsr_master_model.sv */
// Serial master model driving select, clock and data-in pins
`timescale 1ns/1ps
module tsr_master_model (
	// Clock
	input  wire logic i_clk,
	// Device data out
	input  wire logic i_dout,
	input  wire logic i_dout_oe,
	// Pins towards the device
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_din
);
	logic last_q;
	logic line;

	// Released line shows the inverse of the last driven bit
	assign line = i_dout_oe ? i_dout : ~last_q;

	// Last bit the device drove
	always @(posedge i_clk) begin
		if (i_dout_oe)
			last_q <= i_dout;
	end

	// Idle pins
	initial begin
		last_q = 1'b0;
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_din  = 1'b0;
	end

	// Half a serial clock period: 80 ns
	task automatic half();
		repeat (4) @(posedge i_clk);
	endtask

	// Framed access of n rising edges, word MSB first
	task automatic frame(input logic [15:0] w, input int n,
		output logic [31:0] rd);
		rd = '0;
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			o_sclk <= 1'b0;
			o_din  <= w[15 - (i % 16)];
			repeat (3) @(posedge i_clk);
			@(negedge i_clk);
			rd = {rd[30:0], line};
			@(posedge i_clk);
			o_sclk <= 1'b1;
			half();
		end
		o_cs_n <= 1'b1;
		o_din  <= ~o_din;
		half();
	endtask

	// Clock pulses with select high, which must be ignored
	task automatic wiggle(input int n);
		@(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			o_sclk <= 1'b0;
			o_din  <= 1'b0;
			half();
			o_sclk <= 1'b1;
			half();
		end
	endtask
endmodule

/* bench/temp_sensor_serial_readout_bench.sv */
// Self-checking bench of the temperature serial readout
`timescale 1ns/1ps
module temp_sensor_serial_readout_bench;
	localparam int PER  = 2000;
	localparam int CONV = 50;

	logic        clk;
	logic        reset;
	logic        cs_n;
	logic        sclk;
	logic        din;
	logic        dout;
	logic        dout_oe;
	logic [13:0] adc_code;
	logic        analog_on;
	logic        shutdown;
	logic        aon_prev;
	logic [13:0] last_res;
	logic [31:0] lfsr;
	logic [31:0] rd;
	logic        seen;
	int          n_fail;
	int          num_checks;
	int          on_len;
	int          c1;
	int          c2;
	logic [13:0] codes [6] = '{14'h3B00, 14'h3FFF, 14'h0001,
		14'h12C0, 14'h2000, 14'h1FFF};

	// ---------------------------------------------------------
	// Device and master
	// ---------------------------------------------------------
	tsr_top #(.PERIOD_CYCLES(PER), .CONV_CYCLES(CONV)) i_dut (
		.i_clk(clk), .i_reset(reset), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
		.i_adc_code(adc_code), .o_analog_on(analog_on),
		.o_shutdown(shutdown));

	tsr_master_model i_master (
		.i_clk(clk), .i_dout(dout), .i_dout_oe(dout_oe),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

	// Clock of 20 ns
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Result model: code taken when a conversion ends
	always @(posedge clk) begin
		aon_prev <= analog_on;
		if (analog_on)
			on_len <= aon_prev ? on_len + 1 : 1;
		else if (aon_prev)
			last_res <= adc_code;
	end

	// ---------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, got);
		end
	endtask

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask

	// Bounded wait for a conversion level
	task automatic wait_on(input logic lvl, input int lim, output int cyc);
		cyc = 0;
		while (analog_on !== lvl && cyc < lim) begin
			@(posedge clk);
			#1;
			cyc++;
		end
		check("analog_on", analog_on, lvl);
	endtask

	// Full access, frame compared with the modelled register
	task automatic read(input logic [15:0] w, input int n);
		logic [15:0] exp;
		// Let a result that just ended reach the model
		@(posedge clk);
		#1;
		exp = {2'h0, last_res};
		i_master.frame(w, n, rd);
		#1;
		check("frame", rd[15:0], exp);
		if (n == 32)
			check("frame_rep", rd[31:16], exp);
		check("dout_oe", dout_oe, 0);
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		stop_test();
	end

	// ---------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------
	initial begin
		n_fail = 0;
		num_checks = 0;
		on_len = 0;
		aon_prev = 1'b0;
		last_res = '0;
		adc_code = '0;
		lfsr = 32'h7850;
		reset = 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check("dout_oe", dout_oe, 0);
		check("shutdown", shutdown, 0);
		check("analog_on", analog_on, 0);
		done("reset");
		// Signed codes, then random codes; each access converts
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			@(posedge clk);
			adc_code <= (i < 6) ? codes[i] : lfsr[13:0];
			read(16'h0000, (i == 7) ? 32 : 16);
			wait_on(1'b1, 8, c1);
			wait_on(1'b0, CONV + 8, c1);
			check("conv_len", on_len, CONV);
		end
		done("codes");
		// Read while converting gets the older result
		@(posedge clk);
		adc_code <= 14'h0ABC;
		read(16'h0000, 16);
		wait_on(1'b1, 8, c1);
		read(16'h0000, 16);
		read(16'h0000, 16);
		done("busy_read");
		// Periodic timer measured rise to rise
		wait_on(1'b1, 8, c1);
		wait_on(1'b0, CONV + 8, c1);
		wait_on(1'b1, PER + 20, c2);
		check("period", (c1 + c2 >= PER - 2) && (c1 + c2 <= PER + 2), 1);
		wait_on(1'b0, CONV + 8, c1);
		done("period");
		// Shutdown request in the third bit
		read(16'h2000, 16);
		check("shutdown", shutdown, 1);
		i_master.wiggle(16);
		#1;
		check("shutdown", shutdown, 1);
		seen = 1'b0;
		repeat (PER + 100) begin
			@(posedge clk);
			seen = seen | analog_on;
		end
		check("no_conv", seen, 0);
		@(posedge clk);
		adc_code <= 14'h2A55;
		read(16'h2000, 16);
		i_master.frame(16'h0000, 8, rd);
		#1;
		check("shutdown", shutdown, 1);
		done("shutdown");
		// All-zero word leaves shutdown and converts at once
		read(16'h0000, 16);
		check("shutdown", shutdown, 0);
		wait_on(1'b1, 8, c1);
		wait_on(1'b0, CONV + 8, c1);
		read(16'h0000, 16);
		check("wake_code", last_res, 14'h2A55);
		done("wake");
		stop_test();
	end
endmodule
